// File: bench/clmc_core_model.sv
// core-side model: code table reads, miss stalls and lock bookkeeping
`timescale 1ns/1ps
module clmc_core_model (
   input  wire logic                 ref_clk,
   input  wire logic                 lock_write,
   input  wire logic [5:0]           lock_write_slot,
   input  wire logic [13:0]          lock_write_seg,
   output clmc_pkg::clmc_table_read_t table_read,
   output logic                      miss_stall
);
   int pushes;

   initial begin
      table_read = '0;
      miss_stall = 1'b0;
      pushes = 0;
   end

   function automatic logic can_pop(input logic [5:0] ptr);
      return (ptr != 6'h3e) && (pushes > 0) && (pushes <= 61);
   endfunction

   task automatic note_pop();
      pushes--;
   endtask

   task automatic stall(input int n);
      @(posedge ref_clk);
      miss_stall <= 1'b1;
      repeat (n) @(posedge ref_clk);
      miss_stall <= 1'b0;
   endtask

   // released address is inverted so a stale value never looks valid
   task automatic table_rd(input logic [15:0] a, output logic w, output logic [5:0] s,
                           output logic [13:0] g);
      @(posedge ref_clk);
      table_read <= '{valid: 1'b1, addr: a};
      @(posedge ref_clk);
      table_read <= '{valid: 1'b0, addr: ~a};
      #1;
      w = lock_write;
      s = lock_write_slot;
      g = lock_write_seg;
      if (lock_write === 1'b1) pushes++;
   endtask
endmodule

// File: bench/tb.sv
// register-level testbench of the cache lock stack and miss accumulator
`timescale 1ns/1ps
module tb;
   logic                       ref_clk, reset_n, miss_stall, w;
   clmc_pkg::clmc_sfr_req_t    sfr_req;
   clmc_pkg::clmc_table_read_t table_read;
   logic [5:0]                 lookup_slot, lock_write_slot, s;
   logic [7:0]                 sfr_rdata, d;
   logic                       slot_locked, lock_write, cache_all_unlocked;
   logic [13:0]                lock_write_seg, lookup_seg, g;
   int                         n_errors, tests_run;

   clmc_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_req(sfr_req),
      .table_read(table_read), .miss_stall(miss_stall), .lookup_slot(lookup_slot),
      .sfr_rdata(sfr_rdata), .slot_locked(slot_locked), .lock_write(lock_write),
      .lock_write_slot(lock_write_slot), .lock_write_seg(lock_write_seg),
      .cache_all_unlocked(cache_all_unlocked), .lookup_seg(lookup_seg));

   clmc_core_model core (.ref_clk(ref_clk), .lock_write(lock_write),
      .lock_write_slot(lock_write_slot), .lock_write_seg(lock_write_seg),
      .table_read(table_read), .miss_stall(miss_stall));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge ref_clk);
      sfr_req.wr <= 1'b0;
   endtask

   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      sfr_req.rd <= 1'b0;
      #1 v = sfr_rdata;
   endtask

   task automatic look(input logic [5:0] sl);
      @(posedge ref_clk);
      lookup_slot <= sl;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic results();
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      results();
   end

   initial begin
      sfr_req = '0;
      lookup_slot = 6'h00;
      reset_n = 1'b0;
      n_errors = 0;
      tests_run = 0;
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      sfr_rd(8'h9a, d); chk(d, 8'h00);
      sfr_rd(8'ha3, d); chk(d, 8'h00);
      sfr_rd(8'ha2, d); chk(d, 8'h04);
      sfr_rd(8'h55, d); chk(d, 8'h00);
      chk(cache_all_unlocked, 1'b1);
      // 37 stall cycles: high 1, low 2, bit 0 hidden
      core.stall(37);
      sfr_rd(8'h9a, d); chk(d, 8'h01);
      sfr_rd(8'ha2, d); chk(d, 8'h24);
      sfr_wr(8'h9a, 8'h7f);
      core.stall(31);
      sfr_rd(8'h9a, d); chk(d, 8'h7f);
      sfr_rd(8'ha2, d); chk(d, 8'hf4);
      core.stall(1);
      sfr_rd(8'h9a, d); chk(d, 8'h80);
      sfr_rd(8'ha2, d); chk(d, 8'h04);
      // stray low bits that the write must clear
      core.stall(3);
      sfr_wr(8'h9a, 8'h05);
      sfr_rd(8'h9a, d); chk(d, 8'h05);
      sfr_rd(8'ha2, d); chk(d, 8'h04);
      core.table_rd(16'h1234, w, s, g); chk(w, 1'b0);
      sfr_wr(8'ha3, 8'h80);
      core.table_rd(16'h1234, w, s, g); chk({w, s}, 7'h40);
      chk(g, 14'h048d);
      core.table_rd(16'habcd, w, s, g); chk({w, s}, 7'h7f);
      chk(g, 14'h2af3);
      core.table_rd(16'h0100, w, s, g); chk({w, s}, 7'h7e);
      sfr_rd(8'ha3, d); chk(d, 8'hbd);
      look(6'h3f); chk({slot_locked, lookup_seg}, 15'h6af3);
      chk(cache_all_unlocked, 1'b0);
      if (core.can_pop(6'h3d)) begin
         sfr_wr(8'ha3, 8'h40);
         core.note_pop();
      end
      sfr_rd(8'ha3, d); chk(d, 8'h3e);
      look(6'h3e); chk(slot_locked, 1'b0);
      look(6'h3f); chk(slot_locked, 1'b1);
      // two more pushes leave slots 1 and 0 free; pointer bits ignore writes
      sfr_wr(8'ha3, 8'h95);
      sfr_rd(8'ha3, d); chk(d, 8'hbe);
      core.table_rd(16'h2000, w, s, g); chk({w, s}, 7'h7e);
      core.table_rd(16'h2004, w, s, g); chk({w, s}, 7'h7d);
      chk(g, 14'h0801);
      look(6'h3d); chk({slot_locked, lookup_seg}, 15'h4801);
      chk(cache_all_unlocked, 1'b0);
      // mid-run reset brings the pointer back to zero without any pop
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      sfr_rd(8'ha3, d); chk(d, 8'h00);
      look(6'h3f); chk(slot_locked, 1'b0);
      chk(cache_all_unlocked, 1'b1);
      results();
   end
endmodule

// File: src/clmc_defines.svh
// register offsets, field positions and reset values of the cache lock and miss counter
`ifndef CLMC_DEFINES_SVH
`define CLMC_DEFINES_SVH
`define CLMC_ADDR_MISS_ACC    8'h9a
`define CLMC_ADDR_LOCK_CTL    8'ha3
`define CLMC_ADDR_TUNING      8'ha2
`define CLMC_MISS_ACC_RESET   8'h00
`define CLMC_LOCK_CTL_RESET   8'h00
`define CLMC_TUNING_LOW_RESET 4'h4
`define CLMC_SLOT_RESET       6'h00
`define CLMC_SLOT_POP_LIMIT   6'h3e
`define CLMC_BIT_PUSH         7
`define CLMC_BIT_POP          6
`define CLMC_BIT_OVF          7
`define CLMC_ACC_W            12
`define CLMC_HIGH_LSB         5
`define CLMC_SLOTS            64
`define CLMC_SEG_BYTES        4
`define CLMC_SEG_LSB          2
`endif

// File: src/clmc_pkg.sv
// types shared by the cache lock and miss counter
package clmc_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } clmc_sfr_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } clmc_table_read_t;

   typedef enum logic [1:0] {
      CLMC_LK_IDLE,
      CLMC_LK_PUSH,
      CLMC_LK_POP
   } clmc_lock_op_t;
endpackage

// File: src/clmc_seg_mem.sv
// memory of locked segment base addresses, one entry per cache slot
`timescale 1ns/1ps
module clmc_seg_mem (
   input  wire logic        ref_clk,
   input  wire logic        we,
   input  wire logic [5:0]  waddr,
   input  wire logic [13:0] wdata,
   input  wire logic [5:0]  raddr,
   output logic      [13:0] rdata
);
   logic [13:0] mem [0:63];

   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      rdata <= mem[raddr];
   end
endmodule

// File: src/clmc_top.sv
// cache lock stack and miss-penalty accumulator with their special registers
// Notes on behaviour
// R1: push enabled: table read locks segment, decrements pointer
// R2: pop write increments pointer; pop reads zero
// R3: software never pops at pointer 111110b
// R4: software never pops more than pushed
// R5: pointer zero means whole cache unlocked
// R6: software locks at most 61 slots
// R7: read-only 6-bit pointer; slots above locked
// R8: overflow flag sticky until accumulator written
// R9: high field shows accumulator bits 11-5
// R10: bits 4-1 live in tuning register
// R11: accumulator counts every miss stall cycle except one that coincides with a high field write
// R12: high field write clears low 5 bits
// R13: high field read latches bits 4-1
// R14: bit 0 hidden; total equals twice fields
// R15: low field is tuning bits 7-4
// R16: software keeps slots 1 and 0 unlocked
// R17: high write loads bits, clears overflow
`timescale 1ns/1ps
`include "clmc_defines.svh"
module clmc_top (
   input  wire logic                      ref_clk,
   input  wire logic                      reset_n,
   input  wire clmc_pkg::clmc_sfr_req_t   sfr_req,
   input  wire clmc_pkg::clmc_table_read_t table_read,
   input  wire logic                      miss_stall,
   input  wire logic [5:0]                lookup_slot,
   output logic      [7:0]                sfr_rdata,
   output logic                           slot_locked,
   output logic                           lock_write,
   output logic      [5:0]                lock_write_slot,
   output logic      [13:0]               lock_write_seg,
   output logic                           cache_all_unlocked,
   output logic      [13:0]               lookup_seg
);
   logic                          lock_push_enable_r;
   logic [5:0]                    lock_slot_pointer_r;
   logic [`CLMC_ACC_W-1:0]        acc_r;
   logic [`CLMC_ACC_W-1:0]        acc_nxt;
   logic                          miss_penalty_overflow_r;
   logic [3:0]                    miss_penalty_low_field_r;
   logic [3:0]                    tuning_other_r;
   logic                          wr_lock;
   logic                          wr_acc;
   logic                          wr_tun;
   logic                          rd_acc;
   logic                          pop_req;
   logic                          push_req;
   logic                          acc_wrap;
   clmc_pkg::clmc_lock_op_t       lock_op;
   logic [7:0]                    rdata_nxt;

   assign wr_lock  = sfr_req.wr && sfr_req.addr == `CLMC_ADDR_LOCK_CTL;
   assign wr_acc   = sfr_req.wr && sfr_req.addr == `CLMC_ADDR_MISS_ACC;
   assign wr_tun   = sfr_req.wr && sfr_req.addr == `CLMC_ADDR_TUNING;
   assign rd_acc   = sfr_req.rd && sfr_req.addr == `CLMC_ADDR_MISS_ACC;
   assign pop_req  = wr_lock && sfr_req.wdata[`CLMC_BIT_POP];
   // R1: push only while enabled
   assign push_req = lock_push_enable_r && table_read.valid;
   // pop takes priority; a table read in the same cycle is not pushed
   assign lock_op  = pop_req ? clmc_pkg::CLMC_LK_POP :
                     push_req ? clmc_pkg::CLMC_LK_PUSH : clmc_pkg::CLMC_LK_IDLE;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lock_push_enable_r <= 1'b0;
      end else if (wr_lock) begin
         lock_push_enable_r <= sfr_req.wdata[`CLMC_BIT_PUSH];
      end
   end

   // R1: push decrements, R2: pop increments the pointer
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lock_slot_pointer_r <= `CLMC_SLOT_RESET;
      end else begin
         case (lock_op)
            clmc_pkg::CLMC_LK_PUSH: lock_slot_pointer_r <= lock_slot_pointer_r - 6'h01;
            clmc_pkg::CLMC_LK_POP:  lock_slot_pointer_r <= lock_slot_pointer_r + 6'h01;
            default:                lock_slot_pointer_r <= lock_slot_pointer_r;
         endcase
      end
   end

   // R1: segment base (byte address without 2 offset bits) written to slot
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lock_write      <= 1'b0;
         lock_write_slot <= 6'h00;
         lock_write_seg  <= 14'h0000;
      end else begin
         lock_write      <= lock_op == clmc_pkg::CLMC_LK_PUSH;
         lock_write_slot <= lock_slot_pointer_r;
         lock_write_seg  <= table_read.addr[15:`CLMC_SEG_LSB];
      end
   end

   clmc_seg_mem u_seg_mem (
      .ref_clk (ref_clk),
      .we      (lock_op == clmc_pkg::CLMC_LK_PUSH),
      .waddr   (lock_slot_pointer_r),
      .wdata   (table_read.addr[15:`CLMC_SEG_LSB]),
      .raddr   (lookup_slot),
      .rdata   (lookup_seg)
   );

   // R5: pointer zero unlocks all; R7: slots above pointer locked
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cache_all_unlocked <= 1'b1;
         slot_locked        <= 1'b0;
      end else begin
         cache_all_unlocked <= lock_slot_pointer_r == 6'h00;
         slot_locked        <= lock_slot_pointer_r != 6'h00
                               && lookup_slot > lock_slot_pointer_r;
      end
   end

   // R11: count stall cycles; wrap marks overflow
   assign acc_wrap = miss_stall && (&acc_r);

   always_comb begin
      acc_nxt = acc_r;
      if (wr_acc) begin
         // R12: R17: load high bits, clear low five
         acc_nxt = {sfr_req.wdata[6:0], 5'b0_0000};
      end else if (miss_stall) begin
         acc_nxt = acc_r + 12'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         acc_r <= 12'h000;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // R8: sticky until written; R17: write clears it
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         miss_penalty_overflow_r <= 1'b0;
      end else if (wr_acc) begin
         miss_penalty_overflow_r <= 1'b0;
      end else if (acc_wrap) begin
         miss_penalty_overflow_r <= 1'b1;
      end
   end

   // R13: read of high field latches bits 4-1; R14: bit 0 dropped
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         miss_penalty_low_field_r <= 4'h0;
      end else if (rd_acc) begin
         miss_penalty_low_field_r <= acc_r[4:1];
      end
   end

   // other tuning bits 3-0 are storage only here
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         tuning_other_r <= `CLMC_TUNING_LOW_RESET;
      end else if (wr_tun) begin
         tuning_other_r <= sfr_req.wdata[3:0];
      end
   end

   // R9: high field; R10: R15: low field in tuning bits 7-4; R2: pop reads 0
   always_comb begin
      rdata_nxt = 8'h00;
      case (sfr_req.addr)
         `CLMC_ADDR_MISS_ACC: rdata_nxt = {miss_penalty_overflow_r, acc_r[11:5]};
         `CLMC_ADDR_LOCK_CTL: rdata_nxt = {lock_push_enable_r, 1'b0, lock_slot_pointer_r};
         `CLMC_ADDR_TUNING:   rdata_nxt = {miss_penalty_low_field_r, tuning_other_r};
         default:             rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.rd) begin
         sfr_rdata <= rdata_nxt;
      end
   end

   // R1: push lowers pointer by one
   a_push_decrement: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
      push_req && !pop_req |=> lock_slot_pointer_r == $past(lock_slot_pointer_r) - 6'h01)
      else $error("push did not decrement pointer");

   // R1: no push when disabled
   a_push_gated: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
      !lock_push_enable_r && !pop_req |=> $stable(lock_slot_pointer_r))
      else $error("pointer moved without push or pop");

   // R2: pop raises pointer
   a_pop_increment: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
      pop_req |=> lock_slot_pointer_r == $past(lock_slot_pointer_r) + 6'h01)
      else $error("pop did not increment pointer");

   // R2: pop bit reads zero
   a_pop_reads_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
      sfr_req.rd && sfr_req.addr == `CLMC_ADDR_LOCK_CTL |=> !sfr_rdata[`CLMC_BIT_POP])
      else $error("pop bit read back as one");

   // R5: zero pointer unlocks all
   a_zero_unlocked: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
      lock_slot_pointer_r == 6'h00 |=> cache_all_unlocked && !slot_locked)
      else $error("cache not unlocked at zero pointer");

   // R8: overflow sticky
   a_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
      miss_penalty_overflow_r && !wr_acc |=> miss_penalty_overflow_r)
      else $error("overflow flag dropped without write");

   // R8: wrap sets overflow
   a_ovf_set: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
      acc_wrap && !wr_acc |=> miss_penalty_overflow_r && acc_r == 12'h000)
      else $error("wrap did not set overflow");

   // R11: stall counts one
   a_stall_count: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
      miss_stall && !wr_acc |=> acc_r == $past(acc_r) + 12'h001)
      else $error("stall cycle not counted");

   // R12: write clears low bits
   a_write_clears: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
      wr_acc |=> acc_r[4:0] == 5'h00 && acc_r[11:5] == $past(sfr_req.wdata[6:0])
      && !miss_penalty_overflow_r)
      else $error("high write did not load and clear");

   // R13: read latches low field
   a_read_latch: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
      rd_acc |=> miss_penalty_low_field_r == $past(acc_r[4:1]))
      else $error("low field not latched on high read");

   // R7: pointer ignores written bits
   a_ptr_read_only: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
      wr_lock && !pop_req && !push_req |=> $stable(lock_slot_pointer_r))
      else $error("lock control write moved pointer");

   // R1: push reports slot and segment
   a_push_report: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
      push_req && !pop_req |=> lock_write && lock_write_slot == $past(lock_slot_pointer_r)
      && lock_write_seg == $past(table_read.addr[15:`CLMC_SEG_LSB]))
      else $error("push did not report slot and segment");

   // R1: no slot write without push
   a_push_only_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
      !push_req || pop_req |=> !lock_write)
      else $error("slot written without push");

   // R1: push enable follows bit 7
   a_push_enable: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
      wr_lock |=> lock_push_enable_r == $past(sfr_req.wdata[`CLMC_BIT_PUSH]))
      else $error("push enable not loaded");

   // R5: nonzero pointer keeps locks
   a_nonzero_locked: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
      lock_slot_pointer_r != 6'h00 |=> !cache_all_unlocked)
      else $error("cache unlocked at nonzero pointer");

   // R7: slots above pointer locked
   a_slot_above: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
      lock_slot_pointer_r != 6'h00 && lookup_slot > lock_slot_pointer_r |=> slot_locked)
      else $error("slot above pointer not locked");

   // R7: slots at or below pointer free
   a_slot_below: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
      lookup_slot <= lock_slot_pointer_r |=> !slot_locked)
      else $error("slot at or below pointer locked");

   // R7: pointer and enable read back
   a_lock_readback: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
      sfr_req.rd && sfr_req.addr == `CLMC_ADDR_LOCK_CTL |=>
      sfr_rdata[5:0] == $past(lock_slot_pointer_r)
      && sfr_rdata[7] == $past(lock_push_enable_r))
      else $error("lock control read back wrong");

   // R9: flag and high field read back
   a_high_readback: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
      rd_acc |=> sfr_rdata == {$past(miss_penalty_overflow_r), $past(acc_r[11:5])})
      else $error("high field read back wrong");

   // R15: low field in tuning bits 7-4
   a_low_readback: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
      sfr_req.rd && sfr_req.addr == `CLMC_ADDR_TUNING |=>
      sfr_rdata[7:4] == $past(miss_penalty_low_field_r))
      else $error("low field read back wrong");

   // R15: low field moves only on high read
   a_low_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
      !rd_acc |=> $stable(miss_penalty_low_field_r))
      else $error("low field changed without high read");

   // R11: no stall, no count
   a_acc_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
      !miss_stall && !wr_acc |=> $stable(acc_r))
      else $error("accumulator moved without stall");

   // R8: flag rises only on wrap
   a_ovf_only_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
      !miss_penalty_overflow_r && !acc_wrap |=> !miss_penalty_overflow_r)
      else $error("overflow set without wrap");

   // R9: read data stands until next read
   a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
      !sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data changed without read");

   c_push: cover property (@(posedge ref_clk) disable iff (!reset_n) push_req);
   c_pop: cover property (@(posedge ref_clk) disable iff (!reset_n) pop_req);
   c_overflow: cover property (@(posedge ref_clk) disable iff (!reset_n) acc_wrap);
   c_latch: cover property (@(posedge ref_clk) disable iff (!reset_n) rd_acc ##1 sfr_req.rd
      && sfr_req.addr == `CLMC_ADDR_TUNING);
   c_ovf_cleared: cover property (@(posedge ref_clk) disable iff (!reset_n)
      wr_acc && miss_penalty_overflow_r);
endmodule
